// ### common/csp_pkg.sv
// Package for the caption and sync pin register bank: map, layouts, modes
package csp_pkg;

  // ----------------------------------------------------------------
  // Register map: printed subaddresses are word indices
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12; // APB address width
  localparam logic [7:0] IDX_ODD_ONE = 8'h67; // First odd-field caption byte
  localparam logic [7:0] IDX_ODD_TWO = 8'h68; // Second odd-field caption byte
  localparam logic [7:0] IDX_EVEN_ONE = 8'h69; // First even-field extended byte
  localparam logic [7:0] IDX_EVEN_TWO = 8'h6a; // Second even-field extended byte
  localparam logic [7:0] IDX_SYNC_CFG = 8'h6b; // Sync pin configuration byte

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CAPTION_RESET = 8'h00; // Caption bytes after reset
  localparam logic [7:0] CFG_RESET = 8'h00; // Both pins rising-edge inputs

  // ----------------------------------------------------------------
  // Field positions inside the configuration byte
  // ----------------------------------------------------------------
  localparam int unsigned POS_A_FUNC_HI = 7; // Pin A function, high bit
  localparam int unsigned POS_A_FUNC_LO = 6; // Pin A function, low bit
  localparam int unsigned POS_H_SRC = 5; // Horizontal source select
  localparam int unsigned POS_A_DIR = 4; // Pin A direction
  localparam int unsigned POS_A_POL = 3; // Pin A polarity
  localparam int unsigned POS_BLANK_FN = 2; // Blanking function
  localparam int unsigned POS_B_DIR = 1; // Pin B direction
  localparam int unsigned POS_B_POL = 0; // Pin B polarity

  // ----------------------------------------------------------------
  // Field sequence periods in fields
  // ----------------------------------------------------------------
  localparam logic [3:0] FIELD_SEQUENCE_NTSC = 4'h4; // Every fourth field
  localparam logic [3:0] FIELD_SEQUENCE_PAL = 4'h8; // Every eighth field
  localparam logic [3:0] FIELD_SEQUENCE_SECAM = 4'hc; // Every twelfth field

  // Pin A signal type
  typedef enum logic [1:0] {
    FUNC_VSYNC = 2'b00, // Vertical sync each field
    FUNC_FRAME = 2'b01, // Odd/even frame sync
    FUNC_FIELD_SEQUENCE = 2'b10, // Field sequence
    FUNC_NA = 2'b11 // Not applicable
  } csp_func_e;

  // Configuration byte, bit 7 first
  typedef struct packed {
    logic [1:0] pin_a_function; // pin_a_function_hi, pin_a_function_lo
    logic horizontal_source_select;
    logic pin_a_direction;
    logic pin_a_polarity;
    logic blanking_function;
    logic pin_b_direction;
    logic pin_b_polarity;
  } csp_cfg_s;

  // Timing from the encoder's sync generator
  typedef struct packed {
    logic [10:0] h_count; // Pixel position in line
    logic [9:0] line_count; // Line number in field
    logic field_start; // One-cycle pulse per field
    logic odd_field; // High during odd field
    logic vsync_active; // Vertical sync level
    logic pal_mode; // PAL encoding selected
    logic secam_mode; // SECAM encoding selected
    logic sync_mode_select; // Take sync from BT.656 stream
    logic bt656_frame_sync; // Decoded frame sync pulse
    logic caption_line_start; // Pulse at start of caption line
    logic caption_bit_strobe; // Pulse per caption data bit
  } csp_timing_s;

  // Window settings kept by other register blocks
  typedef struct packed {
    logic [10:0] pin_b_pulse_start;
    logic [10:0] pin_b_pulse_end;
    logic [9:0] first_active_line;
    logic [9:0] last_active_line;
  } csp_window_s;

  // Byte address of a register index
  function automatic logic [ADDR_W-1:0] csp_reg_addr(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

endpackage

// ### core/csp_edge_detect.sv
// Polarity-selectable edge detector for a sync pin input
`timescale 1ns/1ns
module csp_edge_detect
  import csp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin_in, // Pin level, synchronous to pclk
  input wire logic falling, // High: falling edge is active
  output logic edge_pulse // One cycle per active edge
);

  // ----------------------------------------------------------------
  // Previous sample
  // ----------------------------------------------------------------
  logic prev; // Last pin level
  logic next_prev; // Next last level
  logic armed; // Low until a real sample exists
  logic next_armed; // Next armed state

  // Track the pin each cycle
  always_comb begin
    next_prev = pin_in;
    next_armed = 1'b1;
  end

  // Register the sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev <= 1'b0;
      armed <= 1'b0;
    end else begin
      prev <= next_prev;
      armed <= next_armed;
    end
  end

  // Edge choice follows polarity; a pin already active at release is no edge
  assign edge_pulse = armed & (falling ? (prev & ~pin_in) : (~prev & pin_in));

endmodule // csp_edge_detect

// ### core/csp_caption_shift.sv
// LSB-first serializer for one field's caption bytes
`timescale 1ns/1ns
module csp_caption_shift
  import csp_pkg::*;
#(
  parameter int unsigned BYTES = 2 // Bytes per caption line
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load, // Start of caption line
  input wire logic strobe, // Advance one bit
  input wire logic [8*BYTES-1:0] data, // Byte one in low bits
  output logic bit_out, // Current caption bit
  output logic busy // Line being sent
);

  localparam int unsigned W = 8 * BYTES; // Bits per line
  localparam int unsigned CW = $clog2(W); // Bit counter width

  // Refuse sizes other than one to four bytes
  if (BYTES < 1 || BYTES > 4) begin : g_bad_bytes
    $error("BYTES must be 1 to 4");
  end

  typedef enum logic {
    CAP_IDLE = 1'b0, // Waiting for caption line
    CAP_SEND = 1'b1 // Shifting bits out
  } csp_cap_e;

  // ----------------------------------------------------------------
  // Shift state
  // ----------------------------------------------------------------
  csp_cap_e state; // Current state
  csp_cap_e next_state; // Next state
  logic [W-1:0] shreg; // Snapshot, bit 0 is the bit on the output now
  logic [W-1:0] next_shreg; // Next snapshot
  logic [CW-1:0] cnt; // Bits sent in this line
  logic [CW-1:0] next_cnt; // Next count
  logic next_bit_out; // Next output bit

  // Snapshot at line start so a late write cannot tear the line
  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_cnt = cnt;
    next_bit_out = bit_out;
    unique case (state)
      CAP_IDLE: begin
        // Idle line sits low
        if (load) begin
          next_shreg = data;
          next_cnt = '0;
          next_bit_out = data[0];
          next_state = CAP_SEND;
        end
      end
      CAP_SEND: begin
        if (load) begin
          // Restart on a fresh line
          next_shreg = data;
          next_cnt = '0;
          next_bit_out = data[0];
        end else if (strobe) begin
          if (cnt == CW'(W - 1)) begin
            next_state = CAP_IDLE;
            next_bit_out = 1'b0;
          end else begin
            // Parity sits in each MSB and goes out unchanged
            next_shreg = {1'b0, shreg[W-1:1]};
            next_bit_out = shreg[1];
            next_cnt = cnt + CW'(1);
          end
        end
      end
    endcase
  end

  // Register the shifter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= CAP_IDLE;
      shreg <= '0;
      cnt <= '0;
      bit_out <= 1'b0;
    end else begin
      state <= next_state;
      shreg <= next_shreg;
      cnt <= next_cnt;
      bit_out <= next_bit_out;
    end
  end

  assign busy = (state == CAP_SEND);

endmodule // csp_caption_shift

// ### core/csp_sync_regs.sv
// Caption byte registers and sync pin configuration with pin logic
// Summary of operation
// - Odd first byte sent LSB first.
// - Even first byte sent LSB first.
// - Pin A function: vsync, frame, sequence.
// - Sequence period 4, 8, 12 fields.
// - Horizontal source: pin B, A or stream.
// - Bit 4 sets pin A output.
// - Bit 3 inverts pin A level and edge.
// - Pin B output gives horizontal reference.
// - Blanking bit suppresses pulse in vertical blanking.
// - Pin B input serves horizontal sync.
// - Pin B input also drives internal blanking.
// - Bit 1 sets pin B output.
// - Bit 0 inverts pin B level and edge.
// - Reset clears configuration byte.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ns
module csp_sync_regs
  import csp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire csp_timing_s timing,
  input wire csp_window_s window,
  input wire logic sync_pin_a_in,
  output logic sync_pin_a_out,
  output logic sync_pin_a_oe,
  input wire logic sync_pin_b_in,
  output logic sync_pin_b_out,
  output logic sync_pin_b_oe,
  output logic h_trigger,
  output logic v_trigger,
  output logic internal_blank,
  output logic caption_bit,
  output logic caption_busy
);

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  logic [7:0] caption_odd_byte_one; // First odd-field byte
  logic [7:0] caption_odd_byte_two; // Second odd-field byte
  logic [7:0] extended_even_byte_one; // First even-field byte
  logic [7:0] extended_even_byte_two; // Second even-field byte
  csp_cfg_s sync_pin_config; // Pin configuration
  logic [7:0] next_odd_one;
  logic [7:0] next_odd_two;
  logic [7:0] next_even_one;
  logic [7:0] next_even_two;
  csp_cfg_s next_cfg;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic setup; // APB setup cycle
  logic access; // APB access cycle
  logic mapped; // Address hits a register

  assign setup = psel & ~penable;
  assign access = psel & penable;
  // Read data is staged in the setup cycle, so no wait state is needed
  assign pready = access;

  // Address hit test
  function automatic logic csp_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    return a == csp_reg_addr(idx);
  endfunction

  assign mapped = csp_hit(paddr, IDX_ODD_ONE) | csp_hit(paddr, IDX_ODD_TWO) | csp_hit(paddr, IDX_EVEN_ONE)
                | csp_hit(paddr, IDX_EVEN_TWO) | csp_hit(paddr, IDX_SYNC_CFG);

  // Write decode and read staging
  always_comb begin
    next_odd_one = caption_odd_byte_one;
    next_odd_two = caption_odd_byte_two;
    next_even_one = extended_even_byte_one;
    next_even_two = extended_even_byte_two;
    next_cfg = sync_pin_config;
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (access && pwrite) begin
      // Writes take effect at the completing edge only
      if (csp_hit(paddr, IDX_ODD_ONE)) begin
        next_odd_one = pwdata[7:0];
      end
      if (csp_hit(paddr, IDX_ODD_TWO)) begin
        next_odd_two = pwdata[7:0];
      end
      if (csp_hit(paddr, IDX_EVEN_ONE)) begin
        next_even_one = pwdata[7:0];
      end
      if (csp_hit(paddr, IDX_EVEN_TWO)) begin
        next_even_two = pwdata[7:0];
      end
      if (csp_hit(paddr, IDX_SYNC_CFG)) begin
        next_cfg = csp_cfg_s'(pwdata[7:0]);
      end
    end
    if (setup) begin
      // Unmapped reads give zero with an error
      next_pslverr = ~mapped;
      next_prdata = '0;
      if (!pwrite) begin
        if (csp_hit(paddr, IDX_ODD_ONE)) begin
          next_prdata = {24'h000000, caption_odd_byte_one};
        end else if (csp_hit(paddr, IDX_ODD_TWO)) begin
          next_prdata = {24'h000000, caption_odd_byte_two};
        end else if (csp_hit(paddr, IDX_EVEN_ONE)) begin
          next_prdata = {24'h000000, extended_even_byte_one};
        end else if (csp_hit(paddr, IDX_EVEN_TWO)) begin
          next_prdata = {24'h000000, extended_even_byte_two};
        end else if (csp_hit(paddr, IDX_SYNC_CFG)) begin
          next_prdata = {24'h000000, sync_pin_config};
        end
      end
    end
  end

  // Register bank flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      caption_odd_byte_one <= CAPTION_RESET;
      caption_odd_byte_two <= CAPTION_RESET;
      extended_even_byte_one <= CAPTION_RESET;
      extended_even_byte_two <= CAPTION_RESET;
      sync_pin_config <= csp_cfg_s'(CFG_RESET);
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      caption_odd_byte_one <= next_odd_one;
      caption_odd_byte_two <= next_odd_two;
      extended_even_byte_one <= next_even_one;
      extended_even_byte_two <= next_even_two;
      sync_pin_config <= next_cfg;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // Caption serializer
  // ----------------------------------------------------------------
  logic [15:0] caption_pair; // Bytes for the current field

  // Odd field carries captions, even field extended data
  assign caption_pair = timing.odd_field ? {caption_odd_byte_two, caption_odd_byte_one}
                                         : {extended_even_byte_two, extended_even_byte_one};

  csp_caption_shift #(.BYTES(2)) u_caption (
    .pclk(pclk),
    .presetn(presetn),
    .load(timing.caption_line_start),
    .strobe(timing.caption_bit_strobe),
    .data(caption_pair),
    .bit_out(caption_bit),
    .busy(caption_busy)
  );

  // ----------------------------------------------------------------
  // Pin input edges
  // ----------------------------------------------------------------
  logic a_edge; // Active edge on pin A
  logic b_edge; // Active edge on pin B

  csp_edge_detect u_edge_a (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(sync_pin_a_in),
    .falling(sync_pin_config.pin_a_polarity),
    .edge_pulse(a_edge)
  );

  csp_edge_detect u_edge_b (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(sync_pin_b_in),
    .falling(sync_pin_config.pin_b_polarity),
    .edge_pulse(b_edge)
  );

  // ----------------------------------------------------------------
  // Field sequence counter and pin outputs
  // ----------------------------------------------------------------
  logic [3:0] seq_count; // Fields since last sequence hit
  logic [3:0] next_seq_count;
  logic [3:0] seq_period; // Fields per sequence
  logic a_level; // Pin A asserted level before polarity
  logic b_horizontal_reference_pulse; // Inside horizontal pulse window
  logic b_active_line; // Inside active lines
  logic next_a_out;
  logic next_b_out;
  logic next_h_trigger;
  logic next_v_trigger;
  logic next_blank;
  logic a_in_mode; // Pin A acts as input
  logic b_in_mode; // Pin B acts as input

  assign a_in_mode = ~sync_pin_config.pin_a_direction;
  assign b_in_mode = ~sync_pin_config.pin_b_direction;
  assign sync_pin_a_oe = sync_pin_config.pin_a_direction;
  assign sync_pin_b_oe = sync_pin_config.pin_b_direction;

  // SECAM outranks PAL in choosing the period
  assign seq_period = timing.secam_mode ? FIELD_SEQUENCE_SECAM : (timing.pal_mode ? FIELD_SEQUENCE_PAL : FIELD_SEQUENCE_NTSC);

  // Pin level, sequence count and trigger selection
  always_comb begin
    next_seq_count = seq_count;
    if (timing.field_start) begin
      // Wrap guards against a period shrinking mid-sequence
      if (seq_count >= seq_period - 4'h1) begin
        next_seq_count = 4'h0;
      end else begin
        next_seq_count = seq_count + 4'h1;
      end
    end
    unique case (csp_func_e'(sync_pin_config.pin_a_function))
      FUNC_VSYNC: a_level = timing.vsync_active;
      FUNC_FRAME: a_level = timing.odd_field;
      FUNC_FIELD_SEQUENCE: a_level = timing.vsync_active & (seq_count == 4'h0);
      default: a_level = 1'b0; // Code 11 drives idle
    endcase
    next_a_out = a_level ^ sync_pin_config.pin_a_polarity;
    b_horizontal_reference_pulse = (timing.h_count >= window.pin_b_pulse_start) && (timing.h_count < window.pin_b_pulse_end);
    b_active_line = (timing.line_count >= window.first_active_line)
                  && (timing.line_count <= window.last_active_line);
    // Reference pulse, cut in vertical blanking when selected
    next_b_out = (b_horizontal_reference_pulse & (~sync_pin_config.blanking_function | b_active_line))
               ^ sync_pin_config.pin_b_polarity;
    // Horizontal source: pin B, else stream or pin A
    if (sync_pin_config.horizontal_source_select) begin
      next_h_trigger = b_edge & b_in_mode & ~timing.sync_mode_select;
    end else if (timing.sync_mode_select) begin
      next_h_trigger = timing.bt656_frame_sync;
    end else begin
      next_h_trigger = a_edge & a_in_mode;
    end
    next_v_trigger = a_edge & a_in_mode & ~timing.sync_mode_select;
    // Pin B level doubles as blanking in this mode
    next_blank = sync_pin_config.blanking_function & b_in_mode & ~timing.sync_mode_select
               & (sync_pin_b_in ^ sync_pin_config.pin_b_polarity);
  end

  // Register pins and triggers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_count <= 4'h0;
      sync_pin_a_out <= 1'b0;
      sync_pin_b_out <= 1'b0;
      h_trigger <= 1'b0;
      v_trigger <= 1'b0;
      internal_blank <= 1'b0;
    end else begin
      seq_count <= next_seq_count;
      sync_pin_a_out <= next_a_out;
      sync_pin_b_out <= next_b_out;
      h_trigger <= next_h_trigger;
      v_trigger <= next_v_trigger;
      internal_blank <= next_blank;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic wr_cfg; // Completing write to the configuration byte
  assign wr_cfg = access & pwrite & csp_hit(paddr, IDX_SYNC_CFG);

  cfg_reset_a: assert property (!$past(presetn) |-> sync_pin_config == csp_cfg_s'(CFG_RESET))
    else $error("config not cleared after reset");
  a_direction_a: assert property (wr_cfg |=> sync_pin_a_oe == $past(pwdata[POS_A_DIR]))
    else $error("pin A direction not applied");
  b_direction_a: assert property (wr_cfg |=> sync_pin_b_oe == $past(pwdata[POS_B_DIR]))
    else $error("pin B direction not applied");
  a_polarity_a: assert property (sync_pin_config.pin_a_function == FUNC_VSYNC |=>
    sync_pin_a_out == ($past(timing.vsync_active) ^ $past(sync_pin_config.pin_a_polarity)))
    else $error("pin A level wrong");
  b_source_a: assert property (sync_pin_config.horizontal_source_select && b_in_mode && b_edge
    && !timing.sync_mode_select |=> h_trigger)
    else $error("pin B edge not taken");
  horizontal_reference_pulse_a: assert property (!sync_pin_config.blanking_function && b_horizontal_reference_pulse |=>
    sync_pin_b_out == !$past(sync_pin_config.pin_b_polarity))
    else $error("reference pulse missing");
  blank_line_a: assert property (sync_pin_config.blanking_function && !b_active_line |=>
    sync_pin_b_out == $past(sync_pin_config.pin_b_polarity))
    else $error("pulse not blanked");
  seq_bound_a: assert property (timing.field_start && seq_count >= seq_period - 4'h1 |=> seq_count == 4'h0)
    else $error("field sequence did not wrap");
  caption_lsb_a: assert property (timing.caption_line_start && timing.odd_field |=>
    caption_bit == $past(caption_odd_byte_one[0]))
    else $error("odd caption LSB not first");
  extended_lsb_a: assert property (timing.caption_line_start && !timing.odd_field |=>
    caption_bit == $past(extended_even_byte_one[0]))
    else $error("even data LSB not first");
  blank_input_a: assert property (!sync_pin_config.blanking_function |=> !internal_blank)
    else $error("blanking without blanking function");

  cfg_write_c: cover property (wr_cfg ##1 sync_pin_a_oe && sync_pin_b_oe);
  seq_hit_c: cover property (sync_pin_config.pin_a_function == FUNC_FIELD_SEQUENCE && timing.field_start && seq_count == 4'h0);
  caption_run_c: cover property (timing.caption_line_start ##1 caption_busy);
  blank_in_c: cover property (internal_blank);

endmodule // csp_sync_regs

// ### verification/csp_source_model.sv
// Far-side video source model driving the two sync pins
`timescale 1ns/1ns
module csp_source_model (
  input wire logic pin_a_out,
  input wire logic pin_a_oe,
  input wire logic pin_b_out,
  input wire logic pin_b_oe,
  input wire logic want_a, // Level the source wants on pin A
  input wire logic want_b, // Level the source wants on pin B
  output logic level_a,
  output logic level_b
);
  // ----------------------------------------------------------------
  // Pin resolution
  // ----------------------------------------------------------------
  // Source lets go of a pin the encoder drives, so no contention
  assign level_a = pin_a_oe ? pin_a_out : want_a;
  assign level_b = pin_b_oe ? pin_b_out : want_b;
endmodule // csp_source_model

// ### verification/caption_and_sync_pin_regs_test.sv
// Self-checking bench for caption bytes and sync pin configuration
`timescale 1ns/1ns
module caption_and_sync_pin_regs_test
  import csp_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, adv = 0, want_a = 0, want_b = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, a_out, a_oe, b_out, b_oe, a_lvl, b_lvl, h_trig, v_trig, blk, busy;
  csp_timing_s tim = '0;
  csp_window_s win = '{11'd100, 11'd200, 10'd20, 10'd250};
  logic [32:0] rdq[$]; // Expected read answers
  logic capq[$]; // Expected caption bits
  int errors = 0, n_compared = 0, seed = 80898, n_h = 0, n_v = 0, n_s, hb, vb, i, k;
  logic [7:0] b[4];
  logic [15:0] w;
  // Output table: cfg, h_count, line, then vsync / pin A / pin B
  logic [7:0] cfg_t[6] = '{8'h12, 8'h1e, 8'h16, 8'h1f, 8'h12, 8'h52};
  logic [10:0] h_t[6] = '{150, 150, 150, 150, 200, 150};
  logic [9:0] ln_t[6] = '{10, 10, 100, 100, 100, 100};
  logic [2:0] ex_t[6] = '{3'b111, 3'b100, 3'b001, 3'b010, 3'b110, 3'b101};
  // Input table: cfg, then stream sync / pin B toggled / h pulses / v pulses
  logic [7:0] tc_t[8] = '{8'h20, 8'h21, 8'h00, 8'h00, 8'h08, 8'h20, 8'h25, 8'h00};
  logic [3:0] tx_t[8] = '{4'h6, 4'h6, 4'h4, 4'h3, 4'h3, 4'h1, 4'h6, 4'ha};

  always #5 pclk = ~pclk;

  csp_source_model far (.pin_a_out(a_out), .pin_a_oe(a_oe), .pin_b_out(b_out), .pin_b_oe(b_oe),
    .want_a(want_a), .want_b(want_b), .level_a(a_lvl), .level_b(b_lvl));

  csp_sync_regs uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .timing(tim), .window(win), .sync_pin_a_in(a_lvl), .sync_pin_a_out(a_out), .sync_pin_a_oe(a_oe),
    .sync_pin_b_in(b_lvl), .sync_pin_b_out(b_out), .sync_pin_b_oe(b_oe), .h_trigger(h_trig),
    .v_trigger(v_trig), .internal_blank(blk), .caption_bit(), .caption_busy(busy));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One APB transfer; entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic [32:0] exp);
    int n;
    if (!wr) rdq.push_back(exp);
    psel <= 1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk) penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      errors++;
      end_of_test();
    end
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask

  // ----------------------------------------------------------------
  // Monitor: pops the oldest note when a result shows
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    adv <= tim.caption_line_start | tim.caption_bit_strobe;
    n_h <= n_h + int'(h_trig);
    n_v <= n_v + int'(v_trig);
    if (adv && capq.size() > 0) begin
      check("caption_bit", uut.caption_bit, capq.pop_front());
      check("caption_busy", busy, capq.size() != 0);
    end
    if (psel && penable && pready && !pwrite) check("prdata", {pslverr, prdata}, rdq.size() ? rdq.pop_front() : 'x);
  end

  // Hang guard
  initial begin
    #1000000;
    errors++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (i = 0; i < 5; i++) apb(0, 8'(IDX_ODD_ONE + i), 0, 0);
    apb(1, 8'h70, 8'h5a, 0);
    apb(0, 8'h70, 0, {1'b1, 32'h0});
    // Caption lines, odd then even; host overwrites mid-line
    for (k = 0; k < 2; k++) begin
      for (i = 0; i < 4; i++) begin
        b[i] = 8'($random(seed));
        b[i][7] = ~^b[i][6:0];
        apb(1, 8'(IDX_ODD_ONE + i), b[i], 0);
        apb(0, 8'(IDX_ODD_ONE + i), 0, {25'h0, b[i]});
      end
      w = k ? {b[3], b[2]} : {b[1], b[0]};
      for (i = 0; i < 16; i++) capq.push_back(w[i]);
      capq.push_back(1'b0);
      tim.odd_field <= (k == 0);
      tim.caption_line_start <= 1;
      @(posedge pclk) tim.caption_line_start <= 0;
      fork
        for (i = 0; i < 16; i++) begin
          @(posedge pclk) tim.caption_bit_strobe <= 1;
          @(posedge pclk) tim.caption_bit_strobe <= 0;
        end
        apb(1, 8'(IDX_ODD_ONE + 2 * k), ~b[2 * k], 0);
      join
      repeat (3) @(posedge pclk);
    end
    // Pins as outputs: level, polarity, reference window
    for (i = 0; i < 6; i++) begin
      apb(1, IDX_SYNC_CFG, cfg_t[i], 0);
      apb(0, IDX_SYNC_CFG, 0, {25'h0, cfg_t[i]});
      tim.h_count <= h_t[i];
      tim.line_count <= ln_t[i];
      tim.vsync_active <= ex_t[i][2];
      repeat (3) @(posedge pclk);
      check("pin oe", {a_oe, b_oe}, 2'b11);
      check("pin A", a_out, ex_t[i][1]);
      check("pin B", b_out, ex_t[i][0]);
    end
    // Field sequence on pin A: one hit per 4, 8 or 12 fields
    apb(1, IDX_SYNC_CFG, 8'h92, 0);
    tim.vsync_active <= 1;
    for (k = 0; k < 3; k++) begin
      tim.pal_mode <= (k == 1);
      tim.secam_mode <= (k == 2);
      n_s = 0;
      for (i = 0; i < 24; i++) begin
        tim.field_start <= 1;
        @(posedge pclk) tim.field_start <= 0;
        repeat (2) @(posedge pclk);
        n_s += int'(a_out);
      end
      check("field_sequence", 33'(n_s), 33'(24 / (4 * (k + 1))));
    end
    // Pins as inputs: edge choice and horizontal source
    for (i = 0; i < 8; i++) begin
      apb(1, IDX_SYNC_CFG, tc_t[i], 0);
      want_a <= tc_t[i][3];
      want_b <= tc_t[i][0];
      tim.sync_mode_select <= tx_t[i][3];
      repeat (4) @(posedge pclk);
      hb = n_h;
      vb = n_v;
      if (tx_t[i][2]) want_b <= !tc_t[i][0];
      else want_a <= !tc_t[i][3];
      tim.bt656_frame_sync <= tx_t[i][3];
      @(posedge pclk) tim.bt656_frame_sync <= 0;
      repeat (3) @(posedge pclk);
      check("internal_blank", blk, tc_t[i][2] & tx_t[i][2]);
      want_a <= tc_t[i][3];
      want_b <= tc_t[i][0];
      repeat (4) @(posedge pclk);
      check("h_trigger", 33'(n_h - hb), tx_t[i][1]);
      check("v_trigger", 33'(n_v - vb), tx_t[i][0]);
    end
    repeat (4) @(posedge pclk);
    check("reads left", 33'(rdq.size()), 0);
    end_of_test();
  end
endmodule // caption_and_sync_pin_regs_test
